// [hw/dual_sampling_adc_serial_port.sv]
// conversion, serial readout and power-down control of the two channel converter port
`include "adc_port_regs.svh"

module dual_sampling_adc_serial_port #(
  parameter int RES = `RES_WIDE, // RULE15
  parameter int IN_W = 16,
  parameter int REF_SETTLE_CYCLES = `REF_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // host pins, both asynchronous to the core clock
  input wire logic convert_strobe,
  input wire logic serial_clk,
  // channel pair levels in LSB units
  input wire logic [IN_W-1:0] first_pair_noninverting,
  input wire logic [IN_W-1:0] first_pair_inverting,
  input wire logic [IN_W-1:0] second_pair_noninverting,
  input wire logic [IN_W-1:0] second_pair_inverting,
  // result pin and status
  output logic serial_result_out,
  output logic serial_result_oe,
  output adc_port_pkg::power_state_e power_state,
  output logic ref_ready
);
  import adc_port_pkg::*;

  localparam logic [5:0] FRAME_END = 6'(`FRAME_SLOTS);
  localparam logic [2:0] NAP_N = 3'(`NAP_PULSES);
  localparam logic [2:0] SLEEP_N = 3'(`SLEEP_PULSES);
  localparam int HALF = `HALF_SLOTS;
  localparam int LEAD = `LEAD_SLOTS;

  // synchronised pin events
  logic convert_strobe_rise;
  logic sck_rise;
  logic sck_fall;
  logic sck_edge;
  logic start_convert_strobe;
  // power and reference state
  logic [2:0] pulses_now;
  logic [2:0] static_q;
  power_state_e pwr_q;
  logic [31:0] settle_q;
  logic ready_q;
  // frame, sample and output state
  logic frame_q;
  logic frame_last;
  logic [5:0] slot_q;
  logic [RES-1:0] held0_q;
  logic [RES-1:0] held1_q;
  logic [RES-1:0] word0_q;
  logic [RES-1:0] word1_q;
  logic sdo_q;
  logic oe_q;
  logic [1:0] slot_now;

  // clamp a differential pair to the code range
  function automatic logic [RES-1:0] saturate(input logic [IN_W-1:0] pos,
                                              input logic [IN_W-1:0] neg);
    logic [IN_W:0] diff;
    diff = {1'b0, pos} - {1'b0, neg};
    if (diff[IN_W]) begin
      return '0; // RULE16
    end else if (diff[IN_W-1:RES] != '0) begin
      return '1; // RULE16
    end
    return diff[RES-1:0];
  endfunction : saturate

  // drive enable and bit for one frame slot: channel 0 in the first half, MSB first
  // words wider than a half minus the lead slots would be cut short
  function automatic logic [1:0] slot_out(input logic [5:0] slot,
                                          input logic [RES-1:0] w0,
                                          input logic [RES-1:0] w1);
    logic [RES-1:0] w;
    int pos;
    w = (slot >= 6'(HALF)) ? w1 : w0;
    pos = int'(slot) % HALF - LEAD;
    if (slot < FRAME_END && pos >= 0 && pos < RES) begin
      return {1'b1, w[RES-1-pos]}; // RULE17
    end
    return 2'b00; // RULE17
  endfunction : slot_out

  pin_sync convert_strobe_sync (
    .clk(core_clk),
    .rst(rst),
    .din(convert_strobe),
    .level(),
    .rise(convert_strobe_rise),
    .fall()
  );

  pin_sync sck_sync (
    .clk(core_clk),
    .rst(rst),
    .din(serial_clk),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // any clock pin edge, rising or falling, clears the static-clock strobe count
  assign sck_edge = sck_rise || sck_fall;
  // strobe pulses seen with no clock edge between them, this one included
  assign pulses_now = sck_edge ? 3'h1 : static_q + 3'h1;
  // only the first strobe after reset or clock activity starts a conversion
  assign start_convert_strobe = convert_strobe_rise && pulses_now == 3'h1 && (pwr_q == PWR_ACTIVE || sck_rise);
  assign slot_now = slot_out(slot_q, word0_q, word1_q);
  // the rise that finds the last slot already shown ends the frame
  assign frame_last = (slot_q == FRAME_END);

  // static-clock strobe counter, saturating at the sleep count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      static_q <= 3'h0;
    end else if (convert_strobe_rise) begin
      static_q <= (pulses_now > SLEEP_N) ? SLEEP_N : pulses_now;
    end else if (sck_edge) begin
      static_q <= 3'h0;
    end
  end

  // power state: strobes with a quiet clock go down, a clock rise wakes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_q <= PWR_ACTIVE;
    end else if (convert_strobe_rise && pulses_now >= SLEEP_N) begin
      pwr_q <= PWR_SLEEP; // RULE6
    end else if (convert_strobe_rise && pulses_now == NAP_N) begin
      pwr_q <= PWR_NAP; // RULE5
    end else if (sck_rise) begin
      pwr_q <= PWR_ACTIVE; // RULE7
    end
  end

  // reference settle timer, restarted by each wake from sleep and at reset
  // ref_ready is advisory: conversions still run and may see an unsettled reference
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_q <= 32'(REF_SETTLE_CYCLES);
      ready_q <= 1'b0;
    end else if (pwr_q == PWR_SLEEP) begin
      settle_q <= 32'(REF_SETTLE_CYCLES); // RULE8
      ready_q <= 1'b0;
    end else if (settle_q != 32'h0) begin
      settle_q <= settle_q - 32'h1;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // sample both pairs together at the conversion start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held0_q <= '0;
      held1_q <= '0;
    end else if (start_convert_strobe) begin
      held0_q <= saturate(first_pair_noninverting, first_pair_inverting); // RULE1
      held1_q <= saturate(second_pair_noninverting, second_pair_inverting); // RULE1
    end
  end

  // hand the previous sample to the shifter, so a frame always lags one conversion
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word0_q <= '0;
      word1_q <= '0;
    end else if (start_convert_strobe) begin
      word0_q <= held0_q; // RULE3
      word1_q <= held1_q; // RULE3
    end
  end

  // slot counter; a clock rise in the strobe's own cycle is too close and is not counted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_q <= 1'b0;
      slot_q <= 6'h0;
    end else if (start_convert_strobe) begin
      frame_q <= 1'b1; // RULE1
      slot_q <= 6'h0; // RULE10
    end else if (convert_strobe_rise) begin
      frame_q <= 1'b0;
    end else if (sck_rise && frame_q) begin
      slot_q <= slot_q + 6'h1; // RULE2
      if (frame_last) begin
        frame_q <= 1'b0;
      end
    end
  end

  // result bit: one slot per clock rise, parked low outside a frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdo_q <= 1'b0;
    end else if (convert_strobe_rise) begin
      sdo_q <= 1'b0;
    end else if (sck_rise) begin
      sdo_q <= frame_q && slot_now[0]; // RULE2
    end
  end

  // output enable: released at a strobe, outside a frame and in idle slots
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else if (convert_strobe_rise) begin
      oe_q <= 1'b0; // RULE4
    end else if (sck_rise) begin
      oe_q <= frame_q && slot_now[1]; // RULE4
    end
  end

  assign serial_result_out = sdo_q;
  assign serial_result_oe = oe_q;
  assign power_state = pwr_q;
  assign ref_ready = ready_q;
endmodule : dual_sampling_adc_serial_port

// [hw/adc_port_regs.svh]
// timing counts, slot layout and pulse counts of the dual sampling converter serial port
// Contract
// [RULE1] A rising convert strobe samples both channel pairs at one instant and starts a conversion.
//         The code samples and starts only on the first strobe after reset or clock activity.
// [RULE2] Each rising serial clock edge advances the conversion and puts the next result bit out.
// [RULE3] The words sent in a frame are the values sampled at the previous conversion start.
// [RULE4] The serial result output is three-state and is released whenever no result bit is shown.
// [RULE5] Two strobe pulses with the serial clock static put the device into light power-down.
// [RULE6] Four or more strobe pulses with the serial clock static put the device into deep sleep.
// [RULE7] At least one serial clock pulse wakes the device from deep sleep.
// [RULE8] After a wake from deep sleep the host waits about 2 ms for the reference to settle.
// [RULE9] The host keeps at least 45 ns between the 32nd clock rise and the next strobe rise.
// [RULE10] A strobe raised less than 3 ns before a clock rise delays the output data by one clock.
// [RULE11] At full rate the host raises the strobe half a clock period before the clock rise.
// [RULE12] The host captures each result bit on the rising serial clock edge.
// [RULE13] During conversion the serial clock period stays between 19.6 ns and 10000 ns.
// [RULE14] Strobes are spaced no closer than 667 ns, at most 1.5 MHz per channel.
// [RULE15] Results carry 14 bits on the wide variant and 12 bits on the base variant.
// [RULE16] Inputs above full scale read all ones and inputs below zero read all zeros.
// [RULE17] A 32-clock frame sends channel 0 then channel 1, MSB first, idle slots three-state.
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

`define CORE_CLK_MHZ 200
`define FRAME_SLOTS 32
`define HALF_SLOTS 16
`define LEAD_SLOTS 2
`define RES_WIDE 14
`define RES_BASE 12
`define NAP_PULSES 2
`define SLEEP_PULSES 4
`define REF_SETTLE_MS 2
`define REF_SETTLE_CYCLES (`REF_SETTLE_MS * 1000 * 1000 * `CORE_CLK_MHZ / 1000)
`define ACQ_MIN_NS 45
`define CONVERT_STROBE_SETUP_NS 3
`define SAMPLE_PERIOD_MIN_NS 667
`define SCK_PERIOD_MIN_PS 19600
`define SCK_PERIOD_MAX_NS 10000

`endif

// [hw/adc_port_pkg.sv]
// types shared by the dual sampling converter serial port
package adc_port_pkg;
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_NAP,
    PWR_SLEEP
  } power_state_e;
endpackage : adc_port_pkg

// [hw/pin_sync.sv]
// three-stage pin synchroniser with agreement filter and edge pulses
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = (s2_q == s3_q);

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (agree) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
  assign rise = agree && s3_q && !level_q;
  assign fall = agree && !s3_q && level_q;
endmodule : pin_sync

// [testbench/adc_port_checker_assertions.sv]
// port assertions for the dual converter serial port
module adc_port_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic convert_strobe,
  input wire logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire adc_port_pkg::power_state_e power_state,
  input wire logic ref_ready
);
  import adc_port_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] age_q;
  // cycles since the clock pin rose; saturates so a static clock reads 15
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      age_q <= 4'hF;
    else if ($rose(serial_clk))
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end
  chk_oe_active: assert property (serial_result_oe |-> power_state == PWR_ACTIVE)
    else $error("oe while down");
  chk_oe_rise: assert property ($rose(serial_result_oe) |-> age_q < 4'h7)
    else $error("oe without clock");
  chk_bit_step: assert property (serial_result_oe && $changed(serial_result_out)
    |-> age_q < 4'h7) else $error("bit without clock");
  chk_strobe_oe: assert property ($rose(convert_strobe) |-> ##[1:6] !serial_result_oe)
    else $error("oe after strobe");
  chk_nap_entry: assert property (power_state == PWR_NAP && $past(power_state) == PWR_ACTIVE
    |-> convert_strobe && age_q == 4'hF) else $error("bad nap");
  chk_sleep_entry: assert property (power_state == PWR_SLEEP && $past(power_state) != PWR_SLEEP
    |-> $past(power_state) == PWR_NAP && convert_strobe) else $error("bad sleep");
  chk_wake_clk: assert property (power_state == PWR_SLEEP && $rose(serial_clk)
    |-> ##[1:6] power_state == PWR_ACTIVE) else $error("no wake");
  chk_ref_wait: assert property ($past(power_state) == PWR_SLEEP && power_state == PWR_ACTIVE
    |-> !ref_ready [*8]) else $error("ready too soon");
  cov_frame: cover property ($rose(serial_result_oe));
  cov_nap: cover property (power_state == PWR_NAP);
  cov_sleep: cover property (power_state == PWR_SLEEP);
endmodule : adc_port_checker

bind dual_sampling_adc_serial_port adc_port_checker i_chk (.core_clk, .rst, .convert_strobe,
  .serial_clk, .serial_result_out, .serial_result_oe, .power_state, .ref_ready);

// [testbench/adc_host_model.sv]
// host model driving strobe and serial clock
module adc_host_model (
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  output logic convert_strobe = 1'b0,
  output logic serial_clk = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [32:0] oe_seen;
  logic [32:0] bit_seen;
  // strobe, then 33 rises of 64 ns; a late strobe lands on the first rise
  task automatic frame(input bit late);
    #0.3 convert_strobe = 1'b1;
    if (!late)
      #32;
    for (int k = 0; k < 33; k++) begin
      serial_clk = 1'b1;
      #32 convert_strobe = 1'b0;
      serial_clk = 1'b0;
      #30 oe_seen[k] = serial_result_oe;
      bit_seen[k] = serial_result_out;
      #2;
    end
    #100;
  endtask : frame
  // strobes with the clock static, a full sampling period apart
  task automatic pulses(input int n);
    repeat (n) begin
      #0.3 convert_strobe = 1'b1;
      #40 convert_strobe = 1'b0;
      #660;
    end
  endtask : pulses
  // one clock pulse, then the clock stands low
  task automatic wake();
    #0.3 serial_clk = 1'b1;
    #32 serial_clk = 1'b0;
    #32;
  endtask : wake
endmodule : adc_host_model

// [testbench/tb_dual_sampling_adc_serial_port.sv]
// self-checking bench for the dual converter serial port
module tb_dual_sampling_adc_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_port_pkg::*;
  localparam int RES = 14;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] p0, n0, p1, n1;
  logic convert_strobe, serial_clk, serial_result_out, serial_result_oe, ref_ready;
  power_state_e power_state;
  int num_errors = 0;
  int num_checks = 0;
  // 200 MHz core clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  dual_sampling_adc_serial_port #(.RES(RES), .REF_SETTLE_CYCLES(50)) i_dut (.core_clk, .rst,
    .convert_strobe, .serial_clk, .first_pair_noninverting(p0), .first_pair_inverting(n0),
    .second_pair_noninverting(p1), .second_pair_inverting(n1), .serial_result_out,
    .serial_result_oe, .power_state, .ref_ready);
  adc_host_model i_host (.serial_result_out, .serial_result_oe, .convert_strobe, .serial_clk);
  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %b exp %b", $time, got, exp);
    end
  endtask : check
  // captured slots against the layout; idle slots must be released
  task automatic check_frame(input logic [RES-1:0] w0, input logic [RES-1:0] w1, input int sh);
    logic [1:0] e;
    int s;
    for (int k = 0; k < 33; k++) begin
      s = k - sh;
      e = 2'b00;
      if (s >= 2 && s < 2 + RES)
        e = {1'b1, w0[RES + 1 - s]};
      if (s >= 18 && s < 18 + RES)
        e = {1'b1, w1[RES + 17 - s]};
      check({i_host.oe_seen[k], i_host.oe_seen[k] & i_host.bit_seen[k]}, e);
    end
  endtask : check_frame
  // zero words first, then held words, then saturated words behind a late strobe
  task automatic t_frames();
    @(posedge core_clk);
    #1 {p0, n0, p1, n1} = 64'h1234_0034_2BBC_0100;
    i_host.frame(1'b0);
    check_frame(14'h0000, 14'h0000, 0);
    @(posedge core_clk);
    #1 {p0, n0, p1, n1} = 64'h0010_0020_8000_0800;
    i_host.frame(1'b0);
    check_frame(14'h1200, 14'h2ABC, 0);
    i_host.frame(1'b1);
    check_frame(14'h0000, 14'h3FFF, 1);
  endtask : t_frames
  // nap after two strobes, sleep after four, one clock pulse wakes
  task automatic t_power();
    i_host.pulses(2);
    check(power_state, PWR_NAP);
    i_host.wake();
    check(power_state, PWR_ACTIVE);
    i_host.pulses(4);
    check(power_state, PWR_SLEEP);
    i_host.wake();
    check({power_state == PWR_ACTIVE, ref_ready}, 2'b10);
    repeat (30) @(posedge core_clk);
    #1 check({1'b0, ref_ready}, 2'b00);
    for (int i = 0; i < 20 && ref_ready !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check({1'b0, ref_ready}, 2'b01);
  endtask : t_power
  // mid-run reset from nap: state clears and the next frame carries zero words
  task automatic t_reset();
    i_host.pulses(2);
    check(power_state, PWR_NAP);
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    check(power_state, PWR_ACTIVE);
    check({serial_result_oe, ref_ready}, 2'b00);
    i_host.frame(1'b0);
    check_frame(14'h0000, 14'h0000, 0);
  endtask : t_reset
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {p0, n0, p1, n1} = '0;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    t_frames();
    t_power();
    t_reset();
    tally_and_finish();
  end
  // the tests need about 15 us; a hang is cut well past that
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_dual_sampling_adc_serial_port
